// ==== hdl/pmrst_generator.sv ====
/*
 power monitor reset generator: drives the active-low system reset line
 from power-fail, reset key, software reset and supply-sense causes.
 assumes all cause inputs are asynchronous pins; the supply sensor itself
 is analog and reports its verdict on supplyOkN against the threshold
 chosen by senseThresholdMv; the backplane line is open-drain.
 the board's own rst is treated as a power-up: it asserts reset and the
 full hold stretch follows its release.
*/
// Behaviour
// - reset asserts for power-fail, reset key, software request or bad supply
// - power-fail low leads to reset after a 2 to 16 ms selectable delay
// - reset stays asserted while supply is reported below the threshold
// - after supply recovers, reset held at least 200 ms more
// - same 200 ms hold applies after every other cause clears
// - supply dropping in operation asserts reset at once
// - threshold is 4.8 V with jumper absent, 4.5 V when fitted
// - backplane line driven only when the drive-enable jumper is fitted, and always during board reset and just after it
`timescale 1ns/100ps
`default_nettype none
module pmrst_generator #(
    parameter int unsigned HOLD_CYC  = pmrst_pkg::HOLD_CYCLES,
    parameter int unsigned DMIN_CYC  = pmrst_pkg::DELAY_MIN_CYC,
    parameter int unsigned DMAX_CYC  = pmrst_pkg::DELAY_MAX_CYC
) (
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst,
    // reset causes, all active low
    input  wire logic        powerFailN,
    input  wire logic        resetKeyN,
    input  wire logic        softResetN,
    input  wire logic        supplyOkN,
    // configuration jumpers, high when fitted
    input  wire logic        reset_drive_enable_jumper,
    input  wire logic        sense_level_select_jumper,
    input  wire logic [2:0]  powerFailDelaySel,
    // backplane open-drain reset line
    output logic             sysResetOut,
    output logic             sysResetOeN,
    // local status
    output logic             resetActive,
    output logic [12:0]      senseThresholdMv
);

    // ----------------------------------------------------------------
    // input synchronisers
    // ----------------------------------------------------------------
    // a pin pulse shorter than one clock may slip through unseen;
    // metastability freedom was chosen over catching such glitches
    localparam int unsigned NIN = 9;
    logic [NIN-1:0] pinSync;
    logic [NIN-1:0] syncRst;
    // jumpers pass the same stages: a loose jumper cannot glitch the line,
    // at the price of two cycles before a new setting takes effect
    assign syncRst = pmrst_pkg::PIN_IDLE;

    pmrst_sync #(.WIDTH(NIN)) i_pmrst_sync (
        .clk_sys    (clk_sys),
        .rst        (rst),
        .async      ({powerFailDelaySel, sense_level_select_jumper,
                      reset_drive_enable_jumper, supplyOkN, softResetN,
                      resetKeyN, powerFailN}),
        .resetValue (syncRst),
        .synced     (pinSync)
    );

    // ----------------------------------------------------------------
    // named views of the synchronised pins
    // ----------------------------------------------------------------
    logic       pfN;
    logic       keyN;
    logic       swN;
    logic       okN;
    logic       driveEn;
    logic       testLevel;
    logic [2:0] delaySel;
    assign pfN       = pinSync[0];
    assign keyN      = pinSync[1];
    assign swN       = pinSync[2];
    assign okN       = pinSync[3];
    assign driveEn   = pinSync[4];
    assign testLevel = pinSync[5];
    assign delaySel  = pinSync[8:6];

    // ----------------------------------------------------------------
    // power-fail delay
    // ----------------------------------------------------------------
    // eight settings spread evenly from the least to the longest delay;
    // integer steps may leave the top setting a few cycles short
    function automatic logic [pmrst_pkg::CNT_W-1:0] delay_of(
        input logic [2:0] sel
    );
        int unsigned span;
        span = (DMAX_CYC - DMIN_CYC) / 7;
        delay_of = pmrst_pkg::CNT_W'(DMIN_CYC + span * sel);
    endfunction : delay_of

    logic [pmrst_pkg::CNT_W-1:0] pfCount;
    logic [pmrst_pkg::CNT_W-1:0] next_pfCount;
    logic                        pfFired;
    logic                        next_pfFired;

    always_comb begin
        next_pfCount = pfCount;
        next_pfFired = pfFired;
        if (pfN) begin
            next_pfCount = '0;
            next_pfFired = 1'b0;
        end else if (!pfFired) begin
            // counts local clock cycles
            // stops at the chosen delay, so a long power fail cannot wrap
            if (pfCount >= delay_of(delaySel) - 1'b1) begin
                next_pfFired = 1'b1;
            end else begin
                next_pfCount = pfCount + 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pfCount <= '0;
            pfFired <= 1'b0;
        end else begin
            pfCount <= next_pfCount;
            pfFired <= next_pfFired;
        end
    end

    // ----------------------------------------------------------------
    // cause collection
    // ----------------------------------------------------------------
    logic cause;
    // bad supply enters directly, no delay
    // software bit idles high, so only a driven low counts
    // power fail enters only once its delay has run out
    assign cause = pfFired | !keyN | !swN | !okN;

    // ----------------------------------------------------------------
    // hold sequencer
    // ----------------------------------------------------------------
    pmrst_pkg::pmrst_state_t     state;
    pmrst_pkg::pmrst_state_t     next_state;
    logic [pmrst_pkg::CNT_W-1:0] holdCount;
    logic [pmrst_pkg::CNT_W-1:0] next_holdCount;
    logic                        next_resetActive;
    logic                        next_sysResetOut;
    logic                        next_sysResetOeN;
    logic [12:0]                 next_senseThresholdMv;

    // last count value of the stretch: state and output registers add
    // the other two cycles; a hold shorter than two cycles is not usable
    localparam logic [pmrst_pkg::CNT_W-1:0] HOLD_LAST =
        pmrst_pkg::CNT_W'(HOLD_CYC - 2);

    always_comb begin
        next_state     = state;
        next_holdCount = holdCount;
        case (state)
            pmrst_pkg::PMRST_ST_ACTIVE: begin
                // stretch starts from zero on the first quiet cycle
                next_holdCount = '0;
                if (!cause) begin
                    next_state = pmrst_pkg::PMRST_ST_HOLD;
                end
            end
            pmrst_pkg::PMRST_ST_HOLD: begin
                if (cause) begin
                    // any returning cause restarts the stretch
                    next_state     = pmrst_pkg::PMRST_ST_ACTIVE;
                    next_holdCount = '0;
                end else if (holdCount >= HOLD_LAST) begin
                    next_state = pmrst_pkg::PMRST_ST_RUN;
                end else begin
                    next_holdCount = holdCount + 1'b1;
                end
            end
            pmrst_pkg::PMRST_ST_RUN: begin
                // line released; any cause takes it back at once
                if (cause) begin
                    next_state = pmrst_pkg::PMRST_ST_ACTIVE;
                end
            end
            default: begin
                next_state = pmrst_pkg::PMRST_ST_ACTIVE;
            end
        endcase

        // ------------------------------------------------------------
        // outputs follow the next state, so they move with it
        // ------------------------------------------------------------
        next_resetActive = (next_state != pmrst_pkg::PMRST_ST_RUN);
        // line pulled low only when the drive jumper is fitted
        // data bit stays low: only the enable moves, as on open drain
        next_sysResetOut = 1'b0;
        next_sysResetOeN = !(next_resetActive && driveEn);
        next_senseThresholdMv = testLevel ? pmrst_pkg::SENSE_TEST_MV
                                          : pmrst_pkg::SENSE_NORMAL_MV;
    end

    // board reset itself asserts system reset: start of a power-up
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state            <= pmrst_pkg::PMRST_ST_ACTIVE;
            holdCount        <= '0;
            resetActive      <= 1'b1;
            sysResetOut      <= 1'b0;
            sysResetOeN      <= 1'b0;
            senseThresholdMv <= pmrst_pkg::SENSE_NORMAL_MV;
        end else begin
            state            <= next_state;
            holdCount        <= next_holdCount;
            resetActive      <= next_resetActive;
            sysResetOut      <= next_sysResetOut;
            sysResetOeN      <= next_sysResetOeN;
            senseThresholdMv <= next_senseThresholdMv;
        end
    end

endmodule : pmrst_generator
`default_nettype wire

// ==== hdl/pmrst_pkg.sv ====
/*
 power monitor reset generator: shared constants and types.
 assumes a 25 MHz local clock; all times are turned into cycle counts here.
*/
package pmrst_pkg;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int unsigned CLK_HZ         = 25_000_000;
    localparam int unsigned HOLD_MS        = 200;
    localparam int unsigned DELAY_MIN_MS   = 2;
    localparam int unsigned DELAY_MAX_MS   = 16;
    localparam int unsigned CYC_PER_MS     = CLK_HZ / 1000;
    localparam int unsigned HOLD_CYCLES    = HOLD_MS * CYC_PER_MS;
    localparam int unsigned DELAY_MIN_CYC  = DELAY_MIN_MS * CYC_PER_MS;
    localparam int unsigned DELAY_MAX_CYC  = DELAY_MAX_MS * CYC_PER_MS;
    localparam int unsigned CNT_W          = 23;

    // ----------------------------------------------------------------
    // sense thresholds in millivolts
    // ----------------------------------------------------------------
    localparam logic [12:0] SENSE_NORMAL_MV = 13'h12C0;
    localparam logic [12:0] SENSE_TEST_MV   = 13'h1194;

    // ----------------------------------------------------------------
    // pin levels held in the synchronisers during reset
    // ----------------------------------------------------------------
    // causes idle high; drive jumper fitted, test level off, delay zero
    localparam logic [8:0]  PIN_IDLE        = 9'h01F;

    // ----------------------------------------------------------------
    // sequencer states
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        PMRST_ST_ACTIVE = 3'b001,
        PMRST_ST_HOLD   = 3'b010,
        PMRST_ST_RUN    = 3'b100
    } pmrst_state_t;

endpackage : pmrst_pkg

// ==== hdl/pmrst_sync.sv ====
/*
 two flip-flop synchroniser for a bundle of asynchronous levels.
 assumes the inputs come from pins; output is safe to read after stage two.
*/
`timescale 1ns/100ps
`default_nettype none
module pmrst_sync #(
    parameter int unsigned WIDTH = 1
) (
    // clock and reset
    input  wire logic             clk_sys,
    input  wire logic             rst,
    // levels
    input  wire logic [WIDTH-1:0] async,
    input  wire logic [WIDTH-1:0] resetValue,
    output logic      [WIDTH-1:0] synced
);

    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] next_stage1;
    logic [WIDTH-1:0] next_synced;

    always_comb begin
        next_stage1 = async;
        next_synced = stage1;
    end

    // reset value is a constant tie at the instance, not a live signal
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            stage1 <= resetValue;
            synced <= resetValue;
        end else begin
            stage1 <= next_stage1;
            synced <= next_synced;
        end
    end

endmodule : pmrst_sync
`default_nettype wire

// ==== tb/pmrst_generator_chk.sv ====
/* port checker for the reset generator, bound into every instance.
   assumes the hold count is handed on from the instance parameter. */
`timescale 1ns/100ps
`default_nettype none
module pmrst_generator_chk #(
    parameter int unsigned HOLD_CYC = 50
) (
    // clock and causes
    input wire logic        clk_sys,
    input wire logic        rst,
    input wire logic        powerFailN,
    input wire logic        resetKeyN,
    input wire logic        softResetN,
    input wire logic        supplyOkN,
    input wire logic        reset_drive_enable_jumper,
    input wire logic        sense_level_select_jumper,
    // outputs
    input wire logic        sysResetOut,
    input wire logic        sysResetOeN,
    input wire logic        resetActive,
    input wire logic [12:0] senseThresholdMv
);
    int quiet;
    int next_quiet;
    // cycles since any cause pin was last seen low
    always_comb begin
        next_quiet = quiet + 1;
        if (rst || !(powerFailN && resetKeyN && softResetN && supplyOkN)) begin
            next_quiet = 0;
        end
    end
    always_ff @(posedge clk_sys) begin
        quiet <= next_quiet;
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    chk_key_asserts:
        assert property ($fell(resetKeyN) |-> ##[1:4] resetActive)
        else $error("reset key ignored");
    chk_soft_asserts:
        assert property ($fell(softResetN) |-> ##[1:4] resetActive)
        else $error("software reset ignored");
    chk_supply_low:
        assert property (!supplyOkN [*4] |-> resetActive)
        else $error("low supply without reset");
    chk_pf_late:
        assert property ($fell(powerFailN) |-> ##[1:90]
            (resetActive || powerFailN))
        else $error("power fail reset too late");
    chk_pf_early:
        assert property (quiet > 3 && !resetActive && $fell(powerFailN) ##1
            (resetKeyN && softResetN && supplyOkN) [*8] |-> !resetActive)
        else $error("power fail reset too early");
    chk_hold_min:
        assert property ($fell(resetActive) |-> quiet >= HOLD_CYC)
        else $error("reset released before hold ran out");
    chk_hold_max:
        assert property (quiet == HOLD_CYC + 8 |-> !resetActive)
        else $error("reset never released");
    chk_no_drive:
        assert property (!reset_drive_enable_jumper [*5] |-> sysResetOeN)
        else $error("line driven with jumper out");
    chk_drive_low:
        assert property (reset_drive_enable_jumper [*5] ##0 resetActive [*2]
            |-> !sysResetOeN && !sysResetOut)
        else $error("line not pulled low");
    chk_thr_test:
        assert property (sense_level_select_jumper [*5]
            |-> senseThresholdMv == 13'h1194)
        else $error("test threshold wrong");
    chk_thr_normal:
        assert property (!sense_level_select_jumper [*5]
            |-> senseThresholdMv == 13'h12C0)
        else $error("normal threshold wrong");
    cover property ($fell(resetActive));
    cover property ($rose(resetActive) && !powerFailN);
    cover property (resetActive && sysResetOeN);
    cover property (resetActive && $fell(resetKeyN) && quiet > 3);
endmodule : pmrst_generator_chk
bind pmrst_generator pmrst_generator_chk #(.HOLD_CYC(HOLD_CYC)) i_chk (.*);
`default_nettype wire

// ==== tb/pmrst_backplane.sv ====
/* far side: pulled-up backplane reset line and the software port pin.
   assumes open-drain drive from the generator. */
`timescale 1ns/100ps
`default_nettype none
module pmrst_backplane (
    // generator side
    input  wire logic sysResetOut,
    input  wire logic sysResetOeN,
    // software port
    input  wire logic portDrive,
    input  wire logic portLevel,
    // levels seen by the boards and the generator
    output logic      sysResetLineN,
    output logic      softResetN
);
    // released line floats up, never keeps the last driven level
    assign sysResetLineN = sysResetOeN ? 1'h1 : sysResetOut;
    // port pin is a pulled-up input until software drives it
    assign softResetN = portDrive ? portLevel : 1'h1;
endmodule : pmrst_backplane
`default_nettype wire

// ==== tb/tb_pmrst_generator.sv ====
/* self-checking bench for the reset generator.
   assumes shortened counts: hold 50, delay 10 to 80 cycles. */
`timescale 1ns/100ps
`default_nettype none
module tb_pmrst_generator;
    localparam int HOLD = 50;
    typedef struct {logic act; logic lineN; int lo; int hi;} pmrst_note_t;
    logic clk_sys = 0, rst = 1, powerFailN = 1, resetKeyN = 1, supplyOkN = 1;
    logic reset_drive_enable_jumper = 1, sense_level_select_jumper = 0;
    logic portDrive = 0, portLevel = 1, prevAct = 1, chkLine = 0, expLine;
    logic [2:0] powerFailDelaySel = 0;
    wire logic sysResetOut, sysResetOeN, resetActive, softResetN, lineN;
    wire logic [12:0] senseThresholdMv;
    int cyc = 0, mismatches = 0, compares = 0;
    pmrst_note_t notes[$], n;
    initial begin
        forever #20 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) cyc <= cyc + 1;
    pmrst_generator #(.HOLD_CYC(HOLD), .DMIN_CYC(10), .DMAX_CYC(80))
    i_pmrst_generator (.clk_sys(clk_sys), .rst(rst), .powerFailN(powerFailN),
        .resetKeyN(resetKeyN), .softResetN(softResetN), .supplyOkN(supplyOkN),
        .reset_drive_enable_jumper(reset_drive_enable_jumper),
        .sense_level_select_jumper(sense_level_select_jumper),
        .powerFailDelaySel(powerFailDelaySel), .sysResetOut(sysResetOut),
        .sysResetOeN(sysResetOeN), .resetActive(resetActive),
        .senseThresholdMv(senseThresholdMv));
    pmrst_backplane i_pmrst_backplane (.sysResetOut(sysResetOut),
        .sysResetOeN(sysResetOeN), .portDrive(portDrive),
        .portLevel(portLevel), .sysResetLineN(lineN), .softResetN(softResetN));
    task automatic check(string what, logic [12:0] seen, logic [12:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic conclude();
        if (mismatches == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : conclude
    // watcher: every edge of resetActive must match the oldest note
    always @(posedge clk_sys) begin
        if (chkLine) begin
            check("line", lineN, expLine);
        end
        chkLine <= 0;
        if (!rst && resetActive !== prevAct) begin
            if (notes.size() > 0) begin
                n = notes.pop_front();
            end else begin
                n = '{prevAct, 1'b1, 0, 0};
            end
            check("level", resetActive, n.act);
            check("when", 13'(cyc >= n.lo && cyc <= n.hi), 13'h1);
            expLine <= n.lineN;
            chkLine <= 1;
        end
        prevAct <= resetActive;
    end
    task automatic note(logic act, int lo, int hi);
        notes.push_back('{act, !(act && reset_drive_enable_jumper),
            cyc + lo, cyc + hi});
    endtask : note
    task automatic settle();
        for (int i = 0; i < 400 && notes.size() > 0; i++) @(posedge clk_sys);
        if (notes.size() > 0) begin
            mismatches++;
            conclude();
        end
    endtask : settle
    task automatic drive(int k, logic v);
        case (k)
            0: resetKeyN <= v;
            1: begin
                portDrive <= 1;
                portLevel <= v;
            end
            2: supplyOkN <= v;
            default: powerFailN <= v;
        endcase
    endtask : drive
    // hold cause k low for len cycles; hi of zero means already in reset
    task automatic pulse(int k, int len, int lo, int hi, bit rel);
        @(posedge clk_sys);
        drive(k, 0);
        if (hi > 0) note(1, lo, hi);
        repeat (len) @(posedge clk_sys);
        drive(k, 1);
        if (rel) note(0, HOLD, HOLD + 8);
        if (rel) settle();
    endtask : pulse
    initial begin
        void'($urandom(14));
        repeat (10) @(posedge clk_sys);
        rst <= 0;
        note(0, HOLD, HOLD + 8);
        settle();
        for (int k = 0; k < 3; k++) pulse(k, 3 + $urandom % 20, 1, 6, 1);
        // board reset in mid-run behaves as a power-up
        rst <= 1;
        repeat (10) @(posedge clk_sys);
        check("rstAct", resetActive, 13'h1);
        check("rstLine", lineN, 13'h0);
        rst <= 0;
        note(0, HOLD, HOLD + 8);
        settle();
        pulse(0, 5, 1, 6, 0);
        repeat (20) @(posedge clk_sys);
        pulse(0, 5, 1, 0, 1);
        for (int s = 0; s < 8; s++) begin
            powerFailDelaySel <= s[2:0];
            pulse(3, 95, 11 + 10 * s, 18 + 10 * s, 1);
        end
        reset_drive_enable_jumper <= 0;
        pulse(2, 4, 1, 6, 1);
        sense_level_select_jumper <= 1;
        repeat (6) @(posedge clk_sys);
        check("thr", senseThresholdMv, 13'h1194);
        sense_level_select_jumper <= 0;
        repeat (6) @(posedge clk_sys);
        check("thr", senseThresholdMv, 13'h12C0);
        conclude();
    end
endmodule : tb_pmrst_generator
`default_nettype wire
